// [common/pcf_pkg.sv]
/*
 * Shared definitions for the parallel ports C to F block: register
 * indices, field positions, timer clock selection code and carriers.
 * Assumes a classic Wishbone master with 32-bit data; each register
 * takes one aligned word at byte address four times its index.
 */
package pcf_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_LATCH_C = 4'h2;
    localparam logic [3:0] IDX_LATCH_D = 4'h3;
    localparam logic [3:0] IDX_DIR_C = 4'h6;
    localparam logic [3:0] IDX_DIR_D = 4'h7;
    localparam logic [3:0] IDX_LATCH_E = 4'h8;
    localparam logic [3:0] IDX_LATCH_F = 4'h9;
    localparam logic [3:0] IDX_DIR_E = 4'hc;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int SYSCLK_EN_BIT = 7;
    localparam int SYSCLK_PIN_BIT = 2;
    localparam int TIMER_A_CLK_PIN_BIT = 6;
    localparam int TIMER_B_CLK_PIN_BIT = 4;
    localparam int SPI_SS_PIN_BIT = 4;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [4:0] ADC_PORT_D_FIRST = 5'h08;
    // prescaler code that picks the external timer clock pin
    localparam logic [2:0] PS_EXT_CLOCK = 3'h7;
    localparam logic [1:0] ELS_GPIO = 2'h0;

    // ----------------------------------------------------------------
    // bus state machine
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WB_IDLE = 2'b01,
        WB_ACK = 2'b10
    } pcf_wb_state_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [5:0] adr;
        logic [31:0] dat;
    } pcf_wb_req_s;

    typedef struct packed {
        logic [4:0] converter_channel_select;
        logic [2:0] timer_a_prescaler_select;
        logic [2:0] timer_b_prescaler_select;
        logic spi_enable_bit;
        logic spi_master_bit;
        logic mode_fault_detect_enable;
        logic [1:0] timer_a_ch0_edge_level_select;
        logic [1:0] timer_a_ch1_edge_level_select;
        logic sci_enable_bit;
    } pcf_periph_ctl_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pcf_pe_drive_s;

endpackage : pcf_pkg

// [src/pcf_ports.sv]
/*
 * Parallel ports C, D, E and the port F data latch, with their direction
 * registers, peripheral pin takeover and the Wishbone register slave.
 * Assumes pin inputs synchronous to clk_i, peripheral controls and drives
 * coming straight from the on-chip modules, pad logic outside.
 */
// Local design decision: the Wishbone slave port.
// Notes on behaviour
// - direction bit 1 drives the pin, 0 leaves it a high-impedance input.
// - clock output enable bit drives the system clock on port C bit 2.
// - while the clock goes out, that pin's direction bit is ignored.
// - reset clears the whole port C direction register and clock enable.
// - data read returns latch where direction is 1, pin level where 0.
// - latch writes succeed whatever the direction; on inputs the read stays the pin.
// - port D converter pin reads 0 when input, latch when output.
// - port D timer pins ignore direction for driving; read latch or 0.
// - port D bits 6 and 4 are timer clocks when prescaler picks them.
// - reset clears port D and port E direction registers.
// - port E bits 7..5 are SPI pins, plain I/O when SPI disabled.
// - port E bit 4 is SPI select unless disabled or master without fault detect.
// - peripheral owned port E pins ignore direction for driving; read still mixes.
// - port E bits 3, 2 are timer A channels when edge/level select nonzero.
// - port E bits 1, 0 are SCI pins, plain I/O when SCI disabled.
// - port E has eight readable, writable latch bits.
// - port F has seven latch bits that reset leaves untouched.
// - port C latch keeps its value through reset; bits 7, 6 read zero.
// - clock output reaches port C bit 2 only with enable bit 7 set.
`timescale 1ns/100ps

module pcf_ports
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire pcf_pkg::pcf_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // peripheral side
    input wire logic sysclk_i,
    input wire pcf_pkg::pcf_periph_ctl_s periph_ctl_i,
    input wire pcf_pkg::pcf_pe_drive_s pe_drive_i,
    // port C pins
    input wire logic [5:0] pc_pin_i,
    output logic [5:0] pc_out_o,
    output logic [5:0] pc_oe_o,
    // port D pins
    input wire logic [7:0] pd_pin_i,
    output logic [7:0] pd_out_o,
    output logic [7:0] pd_oe_o,
    // port E pins
    input wire logic [7:0] pe_pin_i,
    output logic [7:0] pe_out_o,
    output logic [7:0] pe_oe_o,
    // port F latch
    output logic [6:0] pf_latch_o
);
    import pcf_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] latch,
                                            input logic [7:0] pin);
        read_mix = (dir & latch) | (~dir & pin);
    endfunction : read_mix

    function automatic logic wb_hit(input pcf_wb_req_s req, input logic [3:0] idx);
        wb_hit = req.cyc && req.stb && req.we && req.sel[0] && (req.adr[5:2] == idx);
    endfunction : wb_hit

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    pcf_wb_state_e wb_state_r;
    logic [31:0] wb_dat_r;
    logic [5:0] dir_reg_c;
    logic sysclk_out_enable;
    logic [7:0] dir_reg_d;
    logic [7:0] dir_reg_e;
    logic [5:0] latch_c;
    logic [7:0] latch_d;
    logic [7:0] latch_e;
    logic [6:0] latch_f;
    logic wr_ok;

    // writes take effect at the edge where the master sees ack
    assign wr_ok = (wb_state_r == WB_ACK);

    // ----------------------------------------------------------------
    // pin ownership
    // ----------------------------------------------------------------
    logic [7:0] pd_adc;
    logic [7:0] pd_timer;
    logic [7:0] pd_owned;
    logic [7:0] pe_owned;
    logic spi_ss_used;

    always_comb
    begin
        pd_adc = 8'h00;
        for (int b = 0; b < 7; b++)
        begin
            pd_adc[b] = (periph_ctl_i.converter_channel_select == ADC_PORT_D_FIRST + 5'(b));
        end
        pd_timer = 8'h00;
        pd_timer[TIMER_A_CLK_PIN_BIT] = (periph_ctl_i.timer_a_prescaler_select == PS_EXT_CLOCK);
        pd_timer[TIMER_B_CLK_PIN_BIT] = (periph_ctl_i.timer_b_prescaler_select == PS_EXT_CLOCK);
    end

    // owned port D pins feed the converter or a timer and are never driven
    assign pd_owned = pd_adc | pd_timer;

    // a master that ignores mode faults leaves the select pin to software
    assign spi_ss_used = periph_ctl_i.spi_enable_bit
                         && !(periph_ctl_i.spi_master_bit && !periph_ctl_i.mode_fault_detect_enable);

    always_comb
    begin
        pe_owned = 8'h00;
        pe_owned[7:5] = {3{periph_ctl_i.spi_enable_bit}};
        pe_owned[SPI_SS_PIN_BIT] = spi_ss_used;
        pe_owned[3] = (periph_ctl_i.timer_a_ch1_edge_level_select != ELS_GPIO);
        pe_owned[2] = (periph_ctl_i.timer_a_ch0_edge_level_select != ELS_GPIO);
        pe_owned[1:0] = {2{periph_ctl_i.sci_enable_bit}};
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // the clock pin is combinational: a flop at clk_i could not carry it
    always_comb
    begin
        pc_out_o = latch_c;
        pc_oe_o = dir_reg_c;
        if (sysclk_out_enable)
        begin
            pc_out_o[SYSCLK_PIN_BIT] = sysclk_i;
            pc_oe_o[SYSCLK_PIN_BIT] = 1'b1;
        end
    end

    // converter and timer clock pins are inputs only
    assign pd_out_o = latch_d;
    assign pd_oe_o = dir_reg_d & ~pd_owned;

    assign pe_out_o = (pe_owned & pe_drive_i.out) | (~pe_owned & latch_e);
    assign pe_oe_o = (pe_owned & pe_drive_i.oe) | (~pe_owned & dir_reg_e);

    assign pf_latch_o = latch_f;

    // ----------------------------------------------------------------
    // read paths
    // ----------------------------------------------------------------
    logic [7:0] rd_c;
    logic [7:0] rd_d;
    logic [7:0] rd_e;
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_c = read_mix({2'h0, dir_reg_c}, {2'h0, latch_c}, {2'h0, pc_pin_i});
        if (sysclk_out_enable)
        begin
            rd_c[SYSCLK_PIN_BIT] = 1'b0;
        end
    end

    // owned port D pins show 0 instead of the pin when set as input
    assign rd_d = read_mix(dir_reg_d, latch_d, pd_pin_i & ~pd_owned);
    assign rd_e = read_mix(dir_reg_e, latch_e, pe_pin_i);

    always_comb
    begin
        rd_mux = 8'h00;
        unique case (wb_req_i.adr[5:2])
            IDX_LATCH_C: rd_mux = rd_c;
            IDX_LATCH_D: rd_mux = rd_d;
            IDX_DIR_C: rd_mux = {sysclk_out_enable, 1'b0, dir_reg_c};
            IDX_DIR_D: rd_mux = dir_reg_d;
            IDX_LATCH_E: rd_mux = rd_e;
            IDX_LATCH_F: rd_mux = {1'b0, latch_f};
            IDX_DIR_E: rd_mux = dir_reg_e;
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // bus slave: ack one cycle after the request, dropped the next
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_state_r <= WB_IDLE;
        end
        else
        begin
            unique case (wb_state_r)
                WB_IDLE: if (wb_req_i.cyc && wb_req_i.stb) wb_state_r <= WB_ACK;
                WB_ACK: wb_state_r <= WB_IDLE;
                default: wb_state_r <= WB_IDLE;
            endcase
        end
    end

    // read data captured when the request is taken, held through ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_r <= 32'h0000_0000;
        end
        else if (wb_state_r == WB_IDLE && wb_req_i.cyc && wb_req_i.stb)
        begin
            wb_dat_r <= {24'h00_0000, rd_mux};
        end
    end

    assign wb_ack_o = (wb_state_r == WB_ACK);
    assign wb_dat_o = wb_dat_r;

    // ----------------------------------------------------------------
    // direction registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_reg_c <= DIR_RESET[5:0];
            sysclk_out_enable <= 1'b0;
        end
        else if (wr_ok && wb_hit(wb_req_i, IDX_DIR_C))
        begin
            dir_reg_c <= wb_req_i.dat[5:0];
            sysclk_out_enable <= wb_req_i.dat[SYSCLK_EN_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_reg_d <= DIR_RESET;
        end
        else if (wr_ok && wb_hit(wb_req_i, IDX_DIR_D))
        begin
            dir_reg_d <= wb_req_i.dat[7:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_reg_e <= DIR_RESET;
        end
        else if (wr_ok && wb_hit(wb_req_i, IDX_DIR_E))
        begin
            dir_reg_e <= wb_req_i.dat[7:0];
        end
    end

    // ----------------------------------------------------------------
    // data latches: no reset, written whatever the direction
    // ----------------------------------------------------------------
    // no reset keeps pin values across a warm reset; they start unknown at power-up
    always_ff @(posedge clk_i)
    begin
        if (wr_ok && wb_hit(wb_req_i, IDX_LATCH_C))
        begin
            latch_c <= wb_req_i.dat[5:0];
        end
        if (wr_ok && wb_hit(wb_req_i, IDX_LATCH_D))
        begin
            latch_d <= wb_req_i.dat[7:0];
        end
        if (wr_ok && wb_hit(wb_req_i, IDX_LATCH_E))
        begin
            latch_e <= wb_req_i.dat[7:0];
        end
        if (wr_ok && wb_hit(wb_req_i, IDX_LATCH_F))
        begin
            latch_f <= wb_req_i.dat[6:0];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_req_i.we;

    dir_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && wb_hit(wb_req_i, IDX_DIR_D)
        |=> pd_oe_o == ($past(wb_req_i.dat[7:0]) & ~pd_owned))
        else $error("port D driver does not follow direction write");

    clk_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sysclk_out_enable |-> pc_oe_o[SYSCLK_PIN_BIT] && pc_out_o[SYSCLK_PIN_BIT] == sysclk_i)
        else $error("system clock not driven on port C bit 2");

    clk_override_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sysclk_out_enable && !dir_reg_c[SYSCLK_PIN_BIT] |-> pc_oe_o[SYSCLK_PIN_BIT])
        else $error("direction bit affects clock pin");

    clk_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !sysclk_out_enable |-> pc_oe_o == dir_reg_c && pc_out_o === latch_c)
        else $error("clock reaches port C while disabled");

    reset_c_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pc_oe_o == 6'h00 && !sysclk_out_enable)
        else $error("port C direction not cleared by reset");

    reset_de_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> pd_oe_o == 8'h00 && dir_reg_e == 8'h00)
        else $error("port D or E direction not cleared by reset");

    read_mix_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_E
        |-> wb_dat_o[7:0] == $past(read_mix(dir_reg_e, latch_e, pe_pin_i)))
        else $error("port E read does not mix latch and pin");

    write_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && wb_hit(wb_req_i, IDX_LATCH_E) |=> latch_e == $past(wb_req_i.dat[7:0]))
        else $error("port E latch write lost");

    adc_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_D
        |-> (wb_dat_o[7:0] & $past(pd_owned & ~dir_reg_d)) == 8'h00)
        else $error("owned port D input bit not read as 0");

    timer_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.timer_a_prescaler_select == PS_EXT_CLOCK |-> !pd_oe_o[TIMER_A_CLK_PIN_BIT])
        else $error("timer A clock pin driven");

    spi_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !periph_ctl_i.spi_enable_bit |-> pe_oe_o[7:4] == dir_reg_e[7:4])
        else $error("SPI pins not released when SPI disabled");

    sci_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.sci_enable_bit |-> pe_oe_o[1:0] == pe_drive_i.oe[1:0])
        else $error("SCI pins follow direction while SCI enabled");

    latch_f_a: assert property (@(posedge clk_i)
        rst_i |=> pf_latch_o === $past(pf_latch_o))
        else $error("port F latch changed by reset");

    unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_C
        |-> wb_dat_o[7:6] == 2'h0 && ($past(sysclk_out_enable) -> !wb_dat_o[SYSCLK_PIN_BIT]))
        else $error("port C read shows bits that must be zero");

    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");

    ss_slave_a: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.spi_enable_bit && !periph_ctl_i.spi_master_bit
        |-> pe_oe_o[SPI_SS_PIN_BIT] == pe_drive_i.oe[SPI_SS_PIN_BIT])
        else $error("slave select pin follows direction in slave mode");

    timer_chan_a: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.timer_a_ch0_edge_level_select != ELS_GPIO |-> pe_oe_o[2] == pe_drive_i.oe[2])
        else $error("timer channel pin not handed to the timer");

    timer_b_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.timer_b_prescaler_select == PS_EXT_CLOCK |-> !pd_oe_o[TIMER_B_CLK_PIN_BIT])
        else $error("timer B clock pin driven");

    read_c: cover property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_C && sysclk_out_enable);
    spi_slave_c: cover property (@(posedge clk_i) disable iff (rst_i)
        periph_ctl_i.spi_enable_bit && !periph_ctl_i.spi_master_bit && dir_reg_e[SPI_SS_PIN_BIT]);
    adc_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_D && (pd_adc != 8'h00));
    write_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && wb_hit(wb_req_i, IDX_DIR_E));
    timer_pin_c: cover property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_req_i.adr[5:2] == IDX_LATCH_D && (pd_timer != 8'h00));

endmodule : pcf_ports

// [verification/pcf_pin_model.sv]
/*
 * Pad-side model for the parallel ports: resolves every pad from the
 * port drive and an outside driver, and makes the system clock level.
 * Assumes the outside levels come from the bench.
 */
`timescale 1ns/100ps

module pcf_pin_model
(
    // clock
    input wire logic clk_i,
    // port drive
    input wire logic [5:0] pc_out_i,
    input wire logic [5:0] pc_oe_i,
    input wire logic [7:0] pd_out_i,
    input wire logic [7:0] pd_oe_i,
    input wire logic [7:0] pe_out_i,
    input wire logic [7:0] pe_oe_i,
    // outside drivers
    input wire logic [5:0] pc_ext_i,
    input wire logic [7:0] pd_ext_i,
    input wire logic [7:0] pe_ext_i,
    // pad levels
    output logic [5:0] pc_pin_o,
    output logic [7:0] pd_pin_o,
    output logic [7:0] pe_pin_o,
    output logic sysclk_o
);
    logic sysclk_r = 1'b0;

    // an enabled driver wins over the outside level
    assign pc_pin_o = (pc_oe_i & pc_out_i) | (~pc_oe_i & pc_ext_i);
    assign pd_pin_o = (pd_oe_i & pd_out_i) | (~pd_oe_i & pd_ext_i);
    assign pe_pin_o = (pe_oe_i & pe_out_i) | (~pe_oe_i & pe_ext_i);

    // half the bus rate, so a stuck clock output shows up
    always_ff @(posedge clk_i)
    begin
        sysclk_r <= ~sysclk_r;
    end
    assign sysclk_o = sysclk_r;
endmodule : pcf_pin_model

// [verification/parallel_ports_c_to_f_tb.sv]
/*
 * Self-checking bench for the parallel ports block: random port setups
 * with reset, byte-lane and unmapped-address corners.
 * Assumes the pad model beside it and the package register map.
 */
`timescale 1ns/100ps

module parallel_ports_c_to_f_tb;
    import pcf_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pcf_wb_req_s wb_req_i = '0;
    pcf_periph_ctl_s ctl_r = '0;
    pcf_pe_drive_s drv_r = '0;
    logic [31:0] wb_dat_o, seed_r = 32'h565e, r;
    logic wb_ack_o, sysclk_i;
    logic [5:0] pc_pin_i, pc_out_o, pc_oe_o, pc_ext_r = '0;
    logic [7:0] pd_pin_i, pd_out_o, pd_oe_o, pd_ext_r = '0;
    logic [7:0] pe_pin_i, pe_out_o, pe_oe_o, pe_ext_r = '0;
    logic [6:0] pf_latch_o;
    logic [7:0] lc, ld, le, lf, dc, dd, de;
    int miscompares = 0;
    int samples_checked = 0;

    always #50 clk_i = ~clk_i;

    pcf_ports DUT
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sysclk_i(sysclk_i), .periph_ctl_i(ctl_r), .pe_drive_i(drv_r),
        .pc_pin_i(pc_pin_i), .pc_out_o(pc_out_o), .pc_oe_o(pc_oe_o),
        .pd_pin_i(pd_pin_i), .pd_out_o(pd_out_o), .pd_oe_o(pd_oe_o),
        .pe_pin_i(pe_pin_i), .pe_out_o(pe_out_o), .pe_oe_o(pe_oe_o), .pf_latch_o(pf_latch_o)
    );

    pcf_pin_model pads
    (
        .clk_i(clk_i), .pc_out_i(pc_out_o), .pc_oe_i(pc_oe_o), .pd_out_i(pd_out_o), .pd_oe_i(pd_oe_o),
        .pe_out_i(pe_out_o), .pe_oe_i(pe_oe_o), .pc_ext_i(pc_ext_r), .pd_ext_i(pd_ext_r),
        .pe_ext_i(pe_ext_r), .pc_pin_o(pc_pin_i), .pd_pin_o(pd_pin_i), .pe_pin_o(pe_pin_i),
        .sysclk_o(sysclk_i)
    );

    // ----------------------------------------------------------------
    // tasks and expectation functions
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic rnd(output logic [31:0] v);
        repeat (32) seed_r = lfsr(seed_r);
        v = seed_r;
    endtask : rnd

    // one classic cycle; the slave decides when ack comes
    task automatic bus(input logic [3:0] idx, input logic we, input logic [3:0] sel, input logic [31:0] wdat,
                       output logic [31:0] rdat);
        int n;
        @(posedge clk_i);
        wb_req_i <= '{1'b1, 1'b1, we, sel, {idx, 2'b00}, wdat};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            wrap_up();
        end
        rdat = wb_dat_o;
        wb_req_i <= '0;
    endtask : bus

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] v;
        bus(idx, 1'b1, 4'hf, {24'h0, d}, v);
    endtask : wr

    task automatic rd_chk(input string name, input logic [3:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        bus(idx, 1'b0, 4'hf, 32'h0, v);
        check(name, v, {24'h0, exp});
    endtask : rd_chk

    function automatic logic [7:0] own_d(input pcf_periph_ctl_s c);
        logic [7:0] m;
        m = 8'h00;
        if (c.converter_channel_select inside {[ADC_PORT_D_FIRST:ADC_PORT_D_FIRST + 5'h06]})
            m[3'(c.converter_channel_select - ADC_PORT_D_FIRST)] = 1'b1;
        if (c.timer_a_prescaler_select == PS_EXT_CLOCK)
            m[TIMER_A_CLK_PIN_BIT] = 1'b1;
        if (c.timer_b_prescaler_select == PS_EXT_CLOCK)
            m[TIMER_B_CLK_PIN_BIT] = 1'b1;
        return m;
    endfunction : own_d

    function automatic logic [7:0] own_e(input pcf_periph_ctl_s c);
        logic [7:0] m;
        m[7:5] = {3{c.spi_enable_bit}};
        m[SPI_SS_PIN_BIT] = c.spi_enable_bit & ~(c.spi_master_bit & ~c.mode_fault_detect_enable);
        m[3] = c.timer_a_ch1_edge_level_select != ELS_GPIO;
        m[2] = c.timer_a_ch0_edge_level_select != ELS_GPIO;
        m[1:0] = {2{c.sci_enable_bit}};
        return m;
    endfunction : own_e

    task automatic check_all();
        logic [7:0] od, oe, oe_e, out_e, pin_e, rc;
        logic [5:0] oe_c, ckm;
        @(negedge clk_i);
        ckm = {3'b000, dc[SYSCLK_EN_BIT], 2'b00};
        oe_c = dc[5:0] | ckm;
        od = own_d(ctl_r);
        oe = own_e(ctl_r);
        oe_e = (oe & drv_r.oe) | (~oe & de);
        out_e = (oe & drv_r.out) | (~oe & le);
        pin_e = (oe_e & out_e) | (~oe_e & pe_ext_r);
        rc = {2'b00, (lc[5:0] & dc[5:0]) | (pc_ext_r & ~dc[5:0]) & ~ckm};
        check("pc_oe", pc_oe_o, oe_c);
        check("pc_out", pc_out_o & oe_c, (lc[5:0] & dc[5:0] & ~ckm) | (ckm & {6{sysclk_i}}));
        check("pd_oe", pd_oe_o, dd & ~od);
        check("pd_out", pd_out_o & dd & ~od, ld & dd & ~od);
        check("pe_oe", pe_oe_o, oe_e);
        check("pe_out", pe_out_o & oe_e, out_e & oe_e);
        check("pf_latch", pf_latch_o, lf[6:0]);
        rd_chk("latch_c", IDX_LATCH_C, rc & ~{5'h00, ckm[2], 2'b00});
        rd_chk("latch_d", IDX_LATCH_D, (ld & dd) | (pd_ext_r & ~dd & ~od));
        rd_chk("latch_e", IDX_LATCH_E, (le & de) | (pin_e & ~de));
        rd_chk("latch_f", IDX_LATCH_F, {1'b0, lf[6:0]});
        rd_chk("dir_c", IDX_DIR_C, dc & 8'hbf);
        rd_chk("dir_d", IDX_DIR_D, dd);
        rd_chk("dir_e", IDX_DIR_E, de);
    endtask : check_all

    task automatic reset_chk();
        @(negedge clk_i);
        check("pc_oe_rst", pc_oe_o, 6'h00);
        check("pd_oe_rst", pd_oe_o, 8'h00);
        check("pe_oe_rst", pe_oe_o, 8'h00);
        rd_chk("dir_c_rst", IDX_DIR_C, DIR_RESET);
        rd_chk("dir_d_rst", IDX_DIR_D, DIR_RESET);
        rd_chk("dir_e_rst", IDX_DIR_E, DIR_RESET);
    endtask : reset_chk

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        #(100 * 30000);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        do_reset();
        reset_chk();
        for (int i = 0; i < 60; i++)
        begin
            rnd(r);
            ctl_r <= (i == 1) ? '1 : r[18:0];
            drv_r <= r[31:16];
            rnd(r);
            {lf, le, ld, lc} = r;
            rnd(r);
            {dc, dd, de} = r[23:0];
            pc_ext_r <= r[29:24];
            rnd(r);
            pd_ext_r <= r[7:0];
            pe_ext_r <= r[15:8];
            wr(IDX_LATCH_C, lc);
            wr(IDX_LATCH_D, ld);
            wr(IDX_LATCH_E, le);
            wr(IDX_LATCH_F, lf);
            wr(IDX_DIR_C, dc);
            wr(IDX_DIR_D, dd);
            wr(IDX_DIR_E, de);
            ld = ~ld;
            wr(IDX_LATCH_D, ld);
            check_all();
        end
        // a write with byte lane 0 off must leave the latch alone
        bus(IDX_LATCH_D, 1'b1, 4'he, {24'h0, ~ld}, r);
        check_all();
        wr(4'h5, 8'hff);
        rd_chk("unmapped", 4'h5, 8'h00);
        ctl_r <= '0;
        do_reset();
        reset_chk();
        dc = 8'h3f;
        dd = 8'hff;
        de = 8'hff;
        wr(IDX_DIR_C, dc);
        wr(IDX_DIR_D, dd);
        wr(IDX_DIR_E, de);
        check_all();
        wrap_up();
    end
endmodule : parallel_ports_c_to_f_tb
